// [design/fault_ctl_top.v]
`timescale 1ns/1ps
// How it works
// - Bits 7..4 route fault inputs through filter
// - Bits 3..0 enable monitoring of fault inputs
// - Enable bits writable only when protection off
// - Configuration register: ratio, debug, time base
// - Overflow flag on first, skip next N
// - Filter value bits 11..8, zero disables
// - Detection flag needs control, enable, fault
`include "fault_ctl_map.vh"
module fault_ctl_top #(
  parameter NFAULT = 4,
  parameter FW = 4,
  parameter RW = 5,
  parameter CW = 16
) (
  // Clock and reset
  input wire I_MCLK,
  input wire I_SRST,
  // Wishbone slave
  input wire I_WB_CYC,
  input wire I_WB_STB,
  input wire I_WB_WE,
  input wire [7:0] I_WB_ADR,
  input wire [3:0] I_WB_SEL,
  input wire [31:0] I_WB_DAT,
  output reg [31:0] O_WB_DAT,
  output reg O_WB_ACK,
  // Fault pins
  input wire [NFAULT-1:0] I_FAULT,
  // Time base, debug and fault active
  input wire I_EXT_TIMEBASE,
  input wire I_DEBUG,
  output reg O_TIMEBASE,
  output reg [1:0] O_DEBUG_MODE,
  output reg O_FAULT_ACTIVE,
  // Interrupt
  output reg O_IRQ
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [11:0] fault_control_q;
  reg [10:0] config_q;
  reg [2:0] mode_q;
  reg [NFAULT-1:0] fault_flag_q;
  reg [1:0] int_status_q;
  reg [1:0] int_mask_q;
  reg [CW-1:0] period_q;
  reg [CW-1:0] count_q;
  reg ovf_q;
  reg [NFAULT-1:0] s1_q;
  reg [NFAULT-1:0] s2_q;
  reg [NFAULT-1:0] s3_q;
  reg [NFAULT-1:0] clean_q;
  reg [2:0] tb_sync_q;
  reg [2:0] dbg_sync_q;
  reg tb_prev_q;
  reg [NFAULT-1:0] flag_d;
  reg [1:0] int_d;
  reg [31:0] rdata_d;
  wire [NFAULT-1:0] filtered;
  wire [NFAULT-1:0] fault_seen;
  wire ovf_set;
  wire wr_req;
  wire rd_req;
  wire wprot_off;
  wire fault_ctl_on;
  wire [FW-1:0] fault_filter_value;
  wire [NFAULT-1:0] in_en;
  wire [NFAULT-1:0] flt_en;
  wire [RW-1:0] ratio;
  wire ext_tb;
  wire tb_edge;
  wire count_tick;
  wire frozen;
  wire [31:0] wmerge;

  // Merge byte lanes of a write into an old word
  function [31:0] merge;
    input [31:0] old;
    input [31:0] wdat;
    input [3:0] sel;
    integer b;
    begin
      merge = old;
      for (b = 0; b < 4; b = b + 1) begin
        if (sel[b]) begin
          merge[b*8 +: 8] = wdat[b*8 +: 8];
        end
      end
    end
  endfunction

  assign wr_req = I_WB_CYC & I_WB_STB & I_WB_WE & ~O_WB_ACK;
  assign rd_req = I_WB_CYC & I_WB_STB & ~I_WB_WE & ~O_WB_ACK;
  assign wprot_off = mode_q[`MD_WRITE_PROTECT_DISABLE_BIT];
  assign fault_ctl_on = mode_q[`MD_FAULT_CTL_BIT];
  assign fault_filter_value = fault_control_q[`FC_FAULT_FILTER_VALUE_MSB:`FC_FAULT_FILTER_VALUE_LSB];
  assign in_en = fault_control_q[`FC_INEN_LSB +: NFAULT];
  assign flt_en = fault_control_q[`FC_FLEN_LSB +: NFAULT];
  assign ratio = config_q[`CF_RATIO_MSB:`CF_RATIO_LSB];
  assign ext_tb = config_q[`CF_EXTTB_BIT];
  // Addressed word with the written byte lanes laid over it
  assign wmerge = merge(rdata_d, I_WB_DAT, I_WB_SEL);

  // ----------------------------------------
  // Fault input path
  // ----------------------------------------
  // Three stages; a change counts once stages two and three agree
  always @(posedge I_MCLK) begin
    if (I_SRST) begin
      s1_q <= {NFAULT{1'b0}};
      s2_q <= {NFAULT{1'b0}};
      s3_q <= {NFAULT{1'b0}};
      clean_q <= {NFAULT{1'b0}};
      tb_sync_q <= 3'h0;
      dbg_sync_q <= 3'h0;
      tb_prev_q <= 1'b0;
    end else begin
      s1_q <= I_FAULT;
      s2_q <= s1_q;
      s3_q <= s2_q;
      clean_q <= (s2_q & s3_q) | (clean_q & (s2_q | s3_q));
      tb_sync_q <= {tb_sync_q[1:0], I_EXT_TIMEBASE};
      dbg_sync_q <= {dbg_sync_q[1:0], I_DEBUG};
      if (tb_sync_q[1] == tb_sync_q[2]) begin
        tb_prev_q <= tb_sync_q[2];
      end
    end
  end

  // Filter value is live: changing it mid-run may drop a fault
  genvar g;
  generate
    for (g = 0; g < NFAULT; g = g + 1) begin : flt
      fault_filter #(
        .W(FW)
      ) u_filter (
        .i_clk(I_MCLK),
        .i_rst(I_SRST),
        .i_value(fault_filter_value),
        .i_in(clean_q[g]),
        .o_out(filtered[g])
      );
      // Filter enable selects filtered or raw path
      assign fault_seen[g] = flt_en[g] ? filtered[g] : clean_q[g];
    end
  endgenerate

  // ----------------------------------------
  // Counter and overflow ratio
  // ----------------------------------------
  assign tb_edge = (tb_sync_q[1] == tb_sync_q[2]) & tb_sync_q[2] & ~tb_prev_q;
  assign frozen = dbg_sync_q[2] & dbg_sync_q[1] &
                  (config_q[`CF_DEBUG_MSB:`CF_DEBUG_LSB] == `CF_DEBUG_FREEZE);
  assign count_tick = ~frozen & (ext_tb ? tb_edge : 1'b1);

  always @(posedge I_MCLK) begin
    if (I_SRST) begin
      count_q <= {CW{1'b0}};
      ovf_q <= 1'b0;
    end else begin
      ovf_q <= 1'b0;
      if (count_tick) begin
        if (count_q >= period_q) begin
          count_q <= {CW{1'b0}};
          ovf_q <= 1'b1;
        end else begin
          count_q <= count_q + {{(CW-1){1'b0}}, 1'b1};
        end
      end
    end
  end

  overflow_divider #(
    .W(RW)
  ) u_ovf (
    .i_clk(I_MCLK),
    .i_rst(I_SRST),
    .i_ratio(ratio),
    .i_overflow(ovf_q),
    .o_flag_set(ovf_set)
  );

  // ----------------------------------------
  // Register writes and flags
  // ----------------------------------------
  always @* begin
    // Set wins over a concurrent clear
    flag_d = fault_flag_q;
    if (wr_req && I_WB_ADR == `ADR_FAULT_STATUS && I_WB_SEL[0]) begin
      flag_d = fault_flag_q & I_WB_DAT[NFAULT-1:0];
    end
    flag_d = flag_d | ({NFAULT{fault_ctl_on}} & in_en & fault_seen);
    int_d = int_status_q;
    if (wr_req && I_WB_ADR == `ADR_INT_STATUS && I_WB_SEL[0]) begin
      int_d = int_status_q & ~I_WB_DAT[1:0];
    end
    int_d[`IS_OVF_BIT] = int_d[`IS_OVF_BIT] | ovf_set;
    int_d[`IS_FAULT_BIT] = int_d[`IS_FAULT_BIT] | (|flag_d & ~|fault_flag_q);
  end

  always @(posedge I_MCLK) begin
    if (I_SRST) begin
      fault_control_q <= `RST_FAULT_CONTROL;
      config_q <= `RST_CONFIG;
      mode_q <= `RST_MODE;
      fault_flag_q <= {NFAULT{1'b0}};
      int_status_q <= 2'h0;
      int_mask_q <= 2'h0;
      period_q <= `RST_PERIOD;
    end else begin
      fault_flag_q <= flag_d;
      int_status_q <= int_d;
      if (wr_req) begin
        case (I_WB_ADR)
          `ADR_FAULT_CONTROL: begin
            fault_control_q[`FC_FAULT_FILTER_VALUE_MSB:`FC_FAULT_FILTER_VALUE_LSB] <=
              wmerge[`FC_FAULT_FILTER_VALUE_MSB:`FC_FAULT_FILTER_VALUE_LSB];
            if (wprot_off && I_WB_SEL[0]) begin
              fault_control_q[7:0] <= I_WB_DAT[7:0];
            end
          end
          `ADR_TIMER_CONFIGURATION: begin
            config_q <= wmerge[10:0] & `CF_WR_MASK;
          end
          `ADR_MODE: begin
            mode_q <= wmerge[2:0];
          end
          `ADR_INT_MASK: begin
            if (I_WB_SEL[0]) begin
              int_mask_q <= I_WB_DAT[1:0];
            end
          end
          `ADR_COUNTER_CTRL: begin
            period_q <= wmerge[CW-1:0];
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // Read mux and outputs
  // ----------------------------------------
  always @* begin
    rdata_d = 32'h0;
    case (I_WB_ADR)
      `ADR_FAULT_CONTROL: rdata_d = {20'h0, fault_control_q};
      `ADR_TIMER_CONFIGURATION: rdata_d = {21'h0, config_q};
      `ADR_MODE: rdata_d = {29'h0, mode_q};
      `ADR_FAULT_STATUS: rdata_d = {{(32-NFAULT){1'b0}}, fault_flag_q};
      `ADR_INT_STATUS: rdata_d = {30'h0, int_status_q};
      `ADR_INT_MASK: rdata_d = {30'h0, int_mask_q};
      `ADR_COUNTER_CTRL: rdata_d = {count_q, period_q};
      default: rdata_d = 32'h0;
    endcase
  end

  always @(posedge I_MCLK) begin
    if (I_SRST) begin
      O_WB_ACK <= 1'b0;
      O_WB_DAT <= 32'h0;
      O_IRQ <= 1'b0;
      O_TIMEBASE <= 1'b0;
      O_DEBUG_MODE <= 2'h0;
      O_FAULT_ACTIVE <= 1'b0;
    end else begin
      O_WB_ACK <= wr_req | rd_req;
      O_WB_DAT <= rd_req ? rdata_d : 32'h0;
      O_IRQ <= |(int_d & int_mask_q);
      O_TIMEBASE <= config_q[`CF_TBOUT_BIT] & ovf_q;
      O_DEBUG_MODE <= config_q[`CF_DEBUG_MSB:`CF_DEBUG_LSB];
      O_FAULT_ACTIVE <= |flag_d;
    end
  end
endmodule

// [shared/fault_ctl_map.vh]
`ifndef FAULT_CTL_MAP_VH
`define FAULT_CTL_MAP_VH
// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define ADR_FAULT_CONTROL 8'h7c
`define ADR_TIMER_CONFIGURATION 8'h84
`define ADR_MODE 8'h54
`define ADR_FAULT_STATUS 8'h74
`define ADR_INT_STATUS 8'h90
`define ADR_INT_MASK 8'h94
`define ADR_COUNTER_CTRL 8'h98
// ----------------------------------------
// Fault control fields
// ----------------------------------------
`define FC_INEN_LSB 0
`define FC_FLEN_LSB 4
`define FC_FAULT_FILTER_VALUE_LSB 8
`define FC_FAULT_FILTER_VALUE_MSB 11
// ----------------------------------------
// Configuration fields
// ----------------------------------------
`define CF_RATIO_LSB 0
`define CF_RATIO_MSB 4
`define CF_DEBUG_LSB 6
`define CF_DEBUG_MSB 7
`define CF_EXTTB_BIT 9
`define CF_TBOUT_BIT 10
`define CF_WR_MASK 11'h6df
`define CF_DEBUG_FREEZE 2'h1
// ----------------------------------------
// Mode fields
// ----------------------------------------
`define MD_FAULT_CTL_BIT 0
`define MD_WRITE_PROTECT_DISABLE_BIT 2
// ----------------------------------------
// Interrupt status bits
// ----------------------------------------
`define IS_OVF_BIT 0
`define IS_FAULT_BIT 1
// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_FAULT_CONTROL 12'h000
`define RST_CONFIG 11'h000
`define RST_MODE 3'h4
`define RST_PERIOD 16'hffff
`endif

// [design/fault_filter.v]
`timescale 1ns/1ps
// Per-input glitch filter: a new level must hold filter_value+1
// samples before it passes. A value of zero passes straight on.
module fault_filter #(
  parameter W = 4
) (
  // Clock and reset
  input wire i_clk,
  input wire i_rst,
  // Filter control
  input wire [W-1:0] i_value,
  // Signal
  input wire i_in,
  output reg o_out
);
  reg [W-1:0] cnt_q;

  always @(posedge i_clk) begin
    if (i_rst) begin
      cnt_q <= {W{1'b0}};
      o_out <= 1'b0;
    end else if (i_value == {W{1'b0}}) begin
      cnt_q <= {W{1'b0}};
      o_out <= i_in;
    end else if (i_in == o_out) begin
      cnt_q <= {W{1'b0}};
    end else if (cnt_q >= i_value) begin
      cnt_q <= {W{1'b0}};
      o_out <= i_in;
    end else begin
      cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
    end
  end
endmodule

// [design/overflow_divider.v]
`timescale 1ns/1ps
// Passes the first overflow of each group of ratio+1 overflows.
module overflow_divider #(
  parameter W = 5
) (
  // Clock and reset
  input wire i_clk,
  input wire i_rst,
  // Control
  input wire [W-1:0] i_ratio,
  input wire i_overflow,
  output reg o_flag_set
);
  reg [W-1:0] skip_q;

  always @(posedge i_clk) begin
    if (i_rst) begin
      skip_q <= {W{1'b0}};
      o_flag_set <= 1'b0;
    end else begin
      o_flag_set <= 1'b0;
      if (i_overflow) begin
        if (skip_q == {W{1'b0}}) begin
          o_flag_set <= 1'b1;
          skip_q <= i_ratio;
        end else begin
          skip_q <= skip_q - {{(W-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule

// [verification/fault_ctl_checker.sv]
`timescale 1ns/1ps
module fault_ctl_checker (
  // Clock and reset
  input wire I_MCLK,
  input wire I_SRST,
  // Bus
  input wire I_WB_CYC,
  input wire I_WB_STB,
  input wire [31:0] O_WB_DAT,
  input wire O_WB_ACK,
  // Status outputs
  input wire [1:0] O_DEBUG_MODE,
  input wire O_FAULT_ACTIVE,
  input wire O_IRQ
);
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (I_SRST);
  wire req = I_WB_CYC && I_WB_STB;
  a_ack_next_cycle: assert property (req && !O_WB_ACK |=> O_WB_ACK)
    else $error("ack missing one cycle after request");
  a_ack_one_pulse: assert property (O_WB_ACK |=> !O_WB_ACK)
    else $error("ack held too long");
  a_ack_has_cause: assert property (O_WB_ACK |-> $past(req))
    else $error("ack without request");
  a_data_idle_zero: assert property (!O_WB_ACK |-> O_WB_DAT == 32'h0)
    else $error("read data outside ack");
  a_debug_by_write: assert property (
    $changed(O_DEBUG_MODE) |-> O_WB_ACK || $past(O_WB_ACK))
    else $error("debug field changed without write");
  a_fault_flag_sticky: assert property (
    $fell(O_FAULT_ACTIVE) |-> O_WB_ACK || $past(O_WB_ACK))
    else $error("fault flag dropped without write");
  a_irq_clear_write: assert property (
    $fell(O_IRQ) |-> O_WB_ACK || $past(O_WB_ACK))
    else $error("interrupt dropped without write");
  // Own disable: must hold while reset is high
  a_reset_quiet_out: assert property (disable iff (1'b0)
    I_SRST |=> !O_WB_ACK && !O_IRQ && !O_FAULT_ACTIVE)
    else $error("outputs active after reset");
  c_write: cover property (O_WB_ACK && O_WB_DAT == 32'h0);
  c_fault: cover property ($rose(O_FAULT_ACTIVE));
  c_irq: cover property ($rose(O_IRQ));
endmodule
bind fault_ctl_top fault_ctl_checker chk_u (.I_MCLK(I_MCLK),
  .I_SRST(I_SRST), .I_WB_CYC(I_WB_CYC), .I_WB_STB(I_WB_STB),
  .O_WB_DAT(O_WB_DAT), .O_WB_ACK(O_WB_ACK), .O_DEBUG_MODE(O_DEBUG_MODE),
  .O_FAULT_ACTIVE(O_FAULT_ACTIVE), .O_IRQ(O_IRQ));

// [verification/fault_ctl_top_bench.sv]
`timescale 1ns/1ps
`include "fault_ctl_map.vh"
module fault_ctl_top_bench;
  reg mclk = 1'b0;
  reg srst = 1'b1;
  reg cyc = 1'b0;
  reg stb = 1'b0;
  reg we = 1'b0;
  reg [7:0] adr = 8'h00;
  reg [3:0] sel = 4'h0;
  reg [31:0] wdat = 32'h0;
  reg [3:0] fault = 4'h0;
  reg ext_in = 1'b0;
  reg halt_in = 1'b0;
  wire [31:0] rdat;
  wire ack, tbo, fact, irq;
  wire [1:0] dbg;
  reg [31:0] got;
  integer err_count = 0;
  integer checks_done = 0;
  integer i, k;
  reg [31:0] n;
  fault_ctl_top dut_u (.I_MCLK(mclk), .I_SRST(srst), .I_WB_CYC(cyc),
    .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel),
    .I_WB_DAT(wdat), .O_WB_DAT(rdat), .O_WB_ACK(ack), .I_FAULT(fault),
    .I_EXT_TIMEBASE(ext_in), .I_DEBUG(halt_in), .O_TIMEBASE(tbo),
    .O_DEBUG_MODE(dbg), .O_FAULT_ACTIVE(fact), .O_IRQ(irq));
  initial forever #20 mclk = ~mclk;
  // ----------------------------------------
  // Bus and check tasks
  // ----------------------------------------
  // Waits for ack with no limit of its own; the watchdog ends a hang
  task bus(input [7:0] a, input w, input [3:0] s, input [31:0] d);
    begin
      @(posedge mclk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= s;
      wdat <= d;
      @(posedge mclk);
      while (ack !== 1'b1) begin
        @(posedge mclk);
      end
      got = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
    end
  endtask
  task chk(input [31:0] e, input [31:0] v);
    begin
      checks_done = checks_done + 1;
      if (v !== e) begin
        err_count = err_count + 1;
        $display("[FAIL] %0t got %h want %h", $time, v, e);
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    bus(a, 1'b1, 4'hf, d);
  endtask
  task rd(input [7:0] a, input [31:0] e);
    begin
      bus(a, 1'b0, 4'hf, 32'h0);
      chk(e, got);
    end
  endtask
  task idle(input integer c);
    repeat (c) @(posedge mclk);
  endtask
  // Pulse fault pins, then let sync and filter settle
  task pulse(input [3:0] p, input integer c);
    begin
      fault <= p;
      idle(c);
      fault <= 4'h0;
      idle(20);
    end
  endtask
  // Timebase pulses until the next overflow flag
  task count_ovf;
    integer t;
    begin
      k = 0;
      t = 0;
      while (irq !== 1'b1 && t < 1100) begin
        @(posedge mclk);
        if (tbo === 1'b1) k = k + 1;
        t = t + 1;
      end
      if (t >= 1100) begin
        err_count = err_count + 1;
        $display("[FAIL] %0t no overflow flag in time", $time);
      end
    end
  endtask
  task close_out;
    begin
      $display("checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  initial begin
    #400000;
    err_count = err_count + 1;
    close_out;
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge mclk);
    srst <= 1'b0;
    rd(`ADR_FAULT_CONTROL, 32'h0);
    rd(`ADR_TIMER_CONFIGURATION, 32'h0);
    rd(`ADR_MODE, 32'h4);
    wr(8'h00, 32'hffffffff);
    rd(8'h00, 32'h0);
    wr(`ADR_FAULT_CONTROL, 32'hffffffff);
    rd(`ADR_FAULT_CONTROL, 32'hfff);
    wr(`ADR_MODE, 32'h0);
    bus(`ADR_FAULT_CONTROL, 1'b1, 4'h3, 32'h5a0);
    rd(`ADR_FAULT_CONTROL, 32'h5ff);
    wr(`ADR_TIMER_CONFIGURATION, 32'hffffffff);
    rd(`ADR_TIMER_CONFIGURATION, 32'h6df);
    chk(32'h3, {30'h0, dbg});
    // Flag needs fault control on and the pin's enable bit set
    wr(`ADR_MODE, 32'h4);
    wr(`ADR_FAULT_CONTROL, 32'h301);
    pulse(4'h1, 8);
    chk(32'h0, {31'h0, fact});
    wr(`ADR_MODE, 32'h5);
    pulse(4'h2, 8);
    chk(32'h0, {31'h0, fact});
    pulse(4'h1, 2);
    chk(32'h1, {31'h0, fact});
    rd(`ADR_FAULT_STATUS, 32'h1);
    chk(32'h0, {31'h0, irq});
    wr(`ADR_INT_MASK, 32'h2);
    idle(2);
    chk(32'h1, {31'h0, irq});
    wr(`ADR_INT_STATUS, 32'h2);
    idle(2);
    chk(32'h0, {31'h0, irq});
    wr(`ADR_FAULT_STATUS, 32'h0);
    idle(2);
    chk(32'h0, {31'h0, fact});
    wr(`ADR_MODE, 32'h4);
    wr(`ADR_FAULT_CONTROL, 32'h311);
    wr(`ADR_MODE, 32'h5);
    pulse(4'h1, 3);
    chk(32'h0, {31'h0, fact});
    pulse(4'h1, 8);
    chk(32'h1, {31'h0, fact});
    wr(`ADR_INT_MASK, 32'h1);
    wr(`ADR_COUNTER_CTRL, 32'hf);
    for (i = 0; i < 3; i = i + 1) begin
      n = (i == 0) ? 32'd0 : (i == 1) ? 32'd2 : 32'd31;
      wr(`ADR_TIMER_CONFIGURATION, 32'h400 | n);
      wr(`ADR_INT_STATUS, 32'h1);
      idle(2);
      count_ovf;
      wr(`ADR_INT_STATUS, 32'h1);
      idle(2);
      count_ovf;
      chk(n + 32'd1, k);
    end
    // External time base: one count per rising pin edge
    wr(`ADR_TIMER_CONFIGURATION, 32'h600);
    bus(`ADR_COUNTER_CTRL, 1'b0, 4'hf, 32'h0);
    n = {((got[31:16] + 16'd3) % 16'd16), 16'h000f};
    for (i = 0; i < 3; i = i + 1) begin
      ext_in <= 1'b1;
      idle(4);
      ext_in <= 1'b0;
      idle(4);
    end
    rd(`ADR_COUNTER_CTRL, n);
    // Debug field one: counter holds while the halt pin is high
    wr(`ADR_TIMER_CONFIGURATION, 32'h40);
    idle(2);
    chk(32'h1, {30'h0, dbg});
    halt_in <= 1'b1;
    idle(4);
    bus(`ADR_COUNTER_CTRL, 1'b0, 4'hf, 32'h0);
    n = got;
    idle(10);
    rd(`ADR_COUNTER_CTRL, n);
    halt_in <= 1'b0;
    close_out;
  end
endmodule
